//--- design/tkm_ctrl.v
// Behaviour
// (RL1) Slot lasts (256 - preset) times 32 slot clocks.
// (RL2) Selected slot counter overflow sets slot flag and irq request.
// (RL3) Slot overflow stops oscillators and halts all counters.
// (RL4) Start low clears count, shared count, slot counters; preset kept.
// (RL5) Start rising edge runs counters and gates oscillator clocks in.
// (RL6) Any module count overflow sets sticky flag; software writes zero.
// (RL7) Shared count overflow sets sticky flag; software writes zero.
// (RL8) Source select 0 own slot counter, 1 module 0 counter.
// (RL9) Shared count clock is fsys divided by 1, 2, 4 or 8.
// (RL10) Two-bit key oscillator frequency select drives output.
// (RL11) Count values read as low/high bytes; writes ignored.
// (RL12) Ten-bit reference trim split over two registers.
// (RL13) Two-bit mux select routes one of four keys.
// (RL14) Per-module multi-frequency enable bit.
// (RL15) Per-module filter enable bit.
// (RL16) Hop control 0 uses software code, 1 hardware hopping.
// (RL17) Software frequency codes 000..111 drive oscillator select.
// (RL18) Unimplemented bits read as zero.
// (RL19) Slot clock from reference oscillator or fsys/4.
// (RL20) Oscillators enabled only while their enable bits are set.
// (RL21) Pin function select 0 general I/O, 1 touch key.
// (RL22) Module count parameterised two to three; module 0 owns globals.
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`include "tkm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tkm_ctrl #(
  parameter NMOD = 3
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             hsel,
  input  wire [11:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output wire [31:0]      hrdata,
  output wire             hreadyout,
  output wire             hresp,
  input  wire [NMOD-1:0]  key_osc_in,
  input  wire [NMOD-1:0]  ref_osc_in,
  output wire [NMOD-1:0]  key_osc_run,
  output wire [NMOD-1:0]  ref_osc_run,
  output wire [2*NMOD-1:0] key_mux_select,
  output wire [NMOD-1:0]  multi_freq_enable,
  output wire [NMOD-1:0]  filter_enable,
  output wire [NMOD-1:0]  hop_hw_control,
  output wire [3*NMOD-1:0] sw_freq_code,
  output wire [10*NMOD-1:0] ref_cap_trim,
  output wire [4*NMOD-1:0] pin_function_select,
  output wire [1:0]       key_osc_freq_select,
  output wire             touch_irq_request
);
  // ==========================================================
  // Helpers
  // Byte address of a register in module m; only the low byte is compared
  function [7:0] mod_addr;
    input integer m;
    input [4:0]   off;
    reg   [31:0]  full;
    begin
      full = `TKM_A_MBASE + m * `TKM_A_MSTRIDE + off;
      mod_addr = full[7:0];
    end
  endfunction

  // ==========================================================
  // Bus slave: zero wait state, always OKAY
  // No wait states: a write is captured in its data phase and lands at the
  // following edge, so a read right after it already sees the new value.
  // Size is not decoded; every register sits in the low byte of a word.
  reg        wr_pend_ff;
  reg [11:0] wr_addr_ff;
  wire       acc = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end
    else
    begin
      wr_pend_ff <= acc & hwrite;
      wr_addr_ff <= haddr;
    end
  end
  wire [7:0] wd = hwdata[7:0];
  // Module blocks live below 0x100; higher addresses must not alias them
  wire       mwr = wr_pend_ff & (wr_addr_ff[11:8] == 4'h0);

  // ==========================================================
  // Global registers
  reg [7:0]  slot_timer_preset_ff;
  reg        start_ff;
  reg        start_d_ff;
  reg        slot_ov_ff;
  reg        cf_ov_ff;
  reg        s16_ov_ff;
  reg        slot_source_select_ff;
  reg [1:0]  s16_clk_sel_ff;
  reg [1:0]  fsel_ff;
  reg        irq_ff;
  reg [15:0] s16_cnt_ff;
  reg [2:0]  div_ff;
  reg        running_ff;

  // Per-module storage
  reg [7:0]  ctl0_ff [0:NMOD-1];
  reg [7:0]  ctl1_ff [0:NMOD-1];
  reg [9:0]  trim_ff [0:NMOD-1];
  reg [15:0] cnt_ff  [0:NMOD-1];
  reg [7:0]  tmr_ff  [0:NMOD-1];
  reg [4:0]  slot_ff [0:NMOD-1];
  reg [2:0]  kos_ff  [0:NMOD-1];
  reg [2:0]  ros_ff  [0:NMOD-1];
  reg [NMOD-1:0] slot_done_ff;

  // Start is kept delayed by one cycle so only a rising edge opens a window;
  // holding it high never restarts a finished slot.
  wire start_rise = start_ff & ~start_d_ff;
  wire gwr = wr_pend_ff & (wr_addr_ff == `TKM_A_GCTL);

  // Slot clock ticks: synchronised ref oscillator edge, or fsys/4
  wire [NMOD-1:0] ref_tick;
  wire [NMOD-1:0] key_tick;
  wire [NMOD-1:0] slot_tick;
  wire [NMOD-1:0] slot_wrap;
  wire [NMOD-1:0] cnt_wrap;
  genvar g;
  // (RL22) one copy per module
  // Key ticks come from the synchronised level, so a sense oscillator must
  // stay well below fsys/2 to be counted exactly.
  generate
    for (g = 0; g < NMOD; g = g + 1)
    begin : gm
      // Stage one may go metastable; only stages two and three are read
      // A rising edge counts when stage two is high and stage three is still low
      assign ref_tick[g] = ros_ff[g][1] & ~ros_ff[g][2];
      assign key_tick[g] = kos_ff[g][1] & ~kos_ff[g][2];
      // (RL19) slot clock select
      assign slot_tick[g] = ctl1_ff[g][7] ? (div_ff[1:0] == `TKM_DIV_SLOT) : ref_tick[g];
      // (RL1) 8+5 bit chain: timer from preset to 255, 32 passes
      assign slot_wrap[g] = slot_tick[g] & (tmr_ff[g] == 8'hff) & (slot_ff[g] == 5'h1f);
      assign cnt_wrap[g]  = key_tick[g] & (cnt_ff[g] == 16'hffff);
      // (RL20) oscillators gated by enables and the window
      assign key_osc_run[g] = ctl1_ff[g][4] & running_ff;
      assign ref_osc_run[g] = ctl1_ff[g][5] & running_ff;
      // (RL13) mux select
      assign key_mux_select[2*g+1:2*g] = ctl0_ff[g][7:6];
      // (RL14) multi-frequency
      assign multi_freq_enable[g] = ctl0_ff[g][5];
      // (RL15) filter
      assign filter_enable[g] = ctl0_ff[g][4];
      // (RL16) (RL17) software code, ignored under hardware hopping
      assign hop_hw_control[g] = ctl0_ff[g][3];
      assign sw_freq_code[3*g+2:3*g] = ctl0_ff[g][3] ? 3'h0 : ctl0_ff[g][2:0];
      // (RL12) trim code
      assign ref_cap_trim[10*g+9:10*g] = trim_ff[g];
      // (RL21) pin function
      assign pin_function_select[4*g+3:4*g] = ctl1_ff[g][3:0];
    end
  endgenerate

  // (RL8) (RL2) selected overflow: module 0 only, or all modules done
  // With own counters the window closes once the slowest module is done
  wire all_done = &(slot_done_ff | slot_wrap);
  wire slot_end = running_ff & (slot_source_select_ff ? slot_wrap[0] : all_done);
  wire any_cf   = running_ff & (|cnt_wrap);
  // (RL9) shared count divider
  // The divider runs free, so the first prescaled tick of a window may fall
  // up to seven cycles after the window opens.
  wire s16_tick = (s16_clk_sel_ff == 2'h0) ? 1'b1 :
                  (s16_clk_sel_ff == 2'h1) ? (div_ff[0] == 1'b1) :
                  (s16_clk_sel_ff == 2'h2) ? (div_ff[1:0] == 2'h3) : (div_ff == 3'h7);
  wire s16_wrap = running_ff & s16_tick & (s16_cnt_ff == 16'hffff);

  // ==========================================================
  // Global control
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_timer_preset_ff <= `TKM_RST8;
      start_ff       <= 1'b0;
      start_d_ff     <= 1'b0;
      slot_ov_ff     <= 1'b0;
      cf_ov_ff       <= 1'b0;
      s16_ov_ff      <= 1'b0;
      slot_source_select_ff        <= 1'b0;
      s16_clk_sel_ff <= 2'h0;
      fsel_ff        <= 2'h0;
      irq_ff         <= 1'b0;
      s16_cnt_ff     <= 16'h0000;
      div_ff         <= 3'h0;
      running_ff     <= 1'b0;
    end
    else
    begin
      div_ff     <= div_ff + 3'h1;
      start_d_ff <= start_ff;
      irq_ff     <= slot_end;
      if (wr_pend_ff & (wr_addr_ff == `TKM_A_TMR))
        slot_timer_preset_ff <= wd;
      if (wr_pend_ff & (wr_addr_ff == `TKM_A_FSEL))
        fsel_ff <= wd[1:0];
      if (gwr)
      begin
        start_ff       <= wd[`TKM_B_START];
        slot_source_select_ff        <= wd[`TKM_B_SLOT_SOURCE_SELECT];
        s16_clk_sel_ff <= wd[1:0];
      end
      // A software write of one also sets a flag; the hardware set wins
      // when both fall in one cycle.
      // (RL2) slot flag, set wins over software write
      if (slot_end)
        slot_ov_ff <= 1'b1;
      else if (gwr)
        slot_ov_ff <= wd[`TKM_B_SLOTOV];
      // (RL6) sticky module count overflow
      if (any_cf)
        cf_ov_ff <= 1'b1;
      else if (gwr)
        cf_ov_ff <= wd[`TKM_B_CFOV];
      // (RL7) sticky shared count overflow
      if (s16_wrap)
        s16_ov_ff <= 1'b1;
      else if (gwr)
        s16_ov_ff <= wd[`TKM_B_S16OV];
      // (RL4) (RL5) (RL3) run window
      if (!start_ff)
        running_ff <= 1'b0;
      else if (start_rise)
        running_ff <= 1'b1;
      else if (slot_end)
        running_ff <= 1'b0;
      if (!start_ff)
        s16_cnt_ff <= 16'h0000;
      else if (running_ff & s16_tick)
        s16_cnt_ff <= s16_cnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // Per-module registers and counters
  integer m;
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_done_ff <= {NMOD{1'b0}};
      for (m = 0; m < NMOD; m = m + 1)
      begin
        ctl0_ff[m] <= 8'h00;
        ctl1_ff[m] <= 8'h00;
        trim_ff[m] <= 10'h000;
        cnt_ff[m]  <= 16'h0000;
        tmr_ff[m]  <= 8'h00;
        slot_ff[m] <= 5'h00;
        kos_ff[m]  <= 3'h0;
        ros_ff[m]  <= 3'h0;
      end
    end
    else
    begin
      for (m = 0; m < NMOD; m = m + 1)
      begin
        kos_ff[m] <= {kos_ff[m][1:0], key_osc_in[m]};
        ros_ff[m] <= {ros_ff[m][1:0], ref_osc_in[m]};
        if (mwr & (wr_addr_ff[7:0] == mod_addr(m, `TKM_O_CTL0)))
          ctl0_ff[m] <= wd;
        if (mwr & (wr_addr_ff[7:0] == mod_addr(m, `TKM_O_CTL1)))
          ctl1_ff[m] <= wd & 8'hbf;
        if (mwr & (wr_addr_ff[7:0] == mod_addr(m, `TKM_O_TRML)))
          trim_ff[m][7:0] <= wd;
        if (mwr & (wr_addr_ff[7:0] == mod_addr(m, `TKM_O_TRMH)))
          trim_ff[m][9:8] <= wd[1:0];
        // (RL4) cleared while start is low; preset untouched
        if (!start_ff || start_rise)
        begin
          cnt_ff[m]       <= 16'h0000;
          slot_ff[m]      <= 5'h00;
          tmr_ff[m]       <= slot_timer_preset_ff;
          slot_done_ff[m] <= 1'b0;
        end
        // (RL3) counting only inside the window
        else if (running_ff)
        begin
          if (key_tick[m] & ctl1_ff[m][4])
            cnt_ff[m] <= cnt_ff[m] + 16'h0001;
          if (slot_tick[m] & ~slot_done_ff[m])
          begin
            if (tmr_ff[m] == 8'hff)
            begin
              tmr_ff[m]  <= slot_timer_preset_ff;
              slot_ff[m] <= slot_ff[m] + 5'h01;
            end
            else
              tmr_ff[m] <= tmr_ff[m] + 8'h01;
          end
          if (slot_wrap[m])
            slot_done_ff[m] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Read mux; (RL11) counts read only, (RL18) unused bits zero
  reg        rd_pend_ff;
  reg [11:0] rd_addr_ff;
  reg [7:0]  rd_val;
  reg [31:0] hrdata_ff;
  integer    k;
  always @*
  begin
    rd_val = 8'h00;
    case (rd_addr_ff)
      `TKM_A_TMR:  rd_val = slot_timer_preset_ff;
      `TKM_A_GCTL: rd_val = {1'b0, slot_ov_ff, start_ff, cf_ov_ff, s16_ov_ff, slot_source_select_ff, s16_clk_sel_ff};
      `TKM_A_S16L: rd_val = s16_cnt_ff[7:0];
      `TKM_A_S16H: rd_val = s16_cnt_ff[15:8];
      `TKM_A_FSEL: rd_val = {6'h00, fsel_ff};
      default:     rd_val = 8'h00;
    endcase
    // Later matches override earlier ones; module blocks never overlap the
    // global offsets, so the order carries no meaning.
    for (k = 0; k < NMOD; k = k + 1)
    begin
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_CNTL)) rd_val = cnt_ff[k][7:0];
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_CNTH)) rd_val = cnt_ff[k][15:8];
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_TRML)) rd_val = trim_ff[k][7:0];
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_TRMH)) rd_val = {6'h00, trim_ff[k][9:8]};
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_CTL0)) rd_val = ctl0_ff[k];
      if (rd_addr_ff[7:0] == mod_addr(k, `TKM_O_CTL1)) rd_val = ctl1_ff[k];
    end
    if (rd_addr_ff[11:8] != 4'h0)
      rd_val = 8'h00;
  end
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 12'h000;
    end
    else
    begin
      rd_pend_ff <= acc & ~hwrite;
      rd_addr_ff <= haddr;
    end
  end
  // Read data decoded from the sampled address, valid in data phase
  // A mux of flops only: this keeps reads at zero wait states.
  always @*
    hrdata_ff = rd_pend_ff ? {24'h000000, rd_val} : 32'h00000000;
  assign hrdata = hrdata_ff;

  // ==========================================================
  // Outputs
  // (RL10) oscillator frequency select
  assign key_osc_freq_select = fsel_ff;
  // (RL2) one-cycle request per slot end
  assign touch_irq_request = irq_ff;
endmodule // tkm_ctrl
`default_nettype wire

//--- design/tkm_map.vh
`ifndef TKM_MAP_VH
`define TKM_MAP_VH
// Global register byte addresses
`define TKM_A_TMR      12'h000
`define TKM_A_GCTL     12'h004
`define TKM_A_S16L     12'h008
`define TKM_A_S16H     12'h00c
`define TKM_A_FSEL     12'h010
// Per-module block: base plus module index times stride
`define TKM_A_MBASE    12'h040
`define TKM_A_MSTRIDE  12'h020
`define TKM_O_CNTL     5'h00
`define TKM_O_CNTH     5'h04
`define TKM_O_TRML     5'h08
`define TKM_O_TRMH     5'h0c
`define TKM_O_CTL0     5'h10
`define TKM_O_CTL1     5'h14
// Global control field positions
`define TKM_B_SLOTOV   6
`define TKM_B_START    5
`define TKM_B_CFOV     4
`define TKM_B_S16OV    3
`define TKM_B_SLOT_SOURCE_SELECT     2
// Slot timing
`define TKM_SLOT_SPAN  9'h100
`define TKM_SLOT_MULT  6'h20
`define TKM_RST8       8'h00
`define TKM_DIV_SLOT   2'h3
`endif

//--- dv/tkm_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkm_map.vh"
module tkm_ctrl_asserts #(
  parameter NMOD = 3
) (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic                hsel,
  input wire logic [11:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [NMOD-1:0]     key_osc_run,
  input wire logic [NMOD-1:0]     ref_osc_run,
  input wire logic [NMOD-1:0]     hop_hw_control,
  input wire logic [3*NMOD-1:0]   sw_freq_code,
  input wire logic [10*NMOD-1:0]  ref_cap_trim,
  input wire logic [1:0]          key_osc_freq_select,
  input wire logic                touch_irq_request
);
  logic        dp_ff;
  logic        w_ff;
  logic [11:0] a_ff;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      dp_ff <= 1'b0;
      w_ff <= 1'b0;
      a_ff <= 12'h000;
    end
    else
    begin
      dp_ff <= hsel && hready && htrans[1];
      w_ff <= hwrite;
      a_ff <= haddr;
    end
  wire wd = dp_ff && w_ff;
  wire fs = a_ff == `TKM_A_FSEL;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  no_wait_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response");
  irq_pulse_a: assert property (touch_irq_request |=> !touch_irq_request) else $error("irq too long");
  osc_stop_a:
    assert property (touch_irq_request |-> key_osc_run == '0 && ref_osc_run == '0) else $error("osc running");
  hop_zero_a: assert property (hop_hw_control[0] |-> sw_freq_code[2:0] == 3'h0) else $error("sw code leak");
  idle_zero_a: assert property (!dp_ff |-> hrdata == 32'h0) else $error("hrdata idle");
  fsel_rd_a: assert property (dp_ff && !w_ff && fs |-> hrdata[31:2] == 30'h0) else $error("fsel bits");
  fsel_wr_a:
    assert property (wd && fs |=> key_osc_freq_select == $past(hwdata[1:0])) else $error("fsel write");
  fsel_hold_a: assert property (!(wd && fs) |=> $stable(key_osc_freq_select)) else $error("fsel moved");
  trim_wr_a:
    assert property (wd && a_ff == 12'h048 |=> ref_cap_trim[7:0] == $past(hwdata[7:0])) else $error("trim write");
endmodule // tkm_ctrl_asserts
bind tkm_ctrl tkm_ctrl_asserts #(.NMOD(NMOD)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .key_osc_run(key_osc_run), .ref_osc_run(ref_osc_run),
  .hop_hw_control(hop_hw_control), .sw_freq_code(sw_freq_code), .ref_cap_trim(ref_cap_trim),
  .key_osc_freq_select(key_osc_freq_select), .touch_irq_request(touch_irq_request));
`default_nettype wire

//--- dv/tkm_pads.sv
`timescale 1ns/1ps
`default_nettype none
module tkm_pads #(
  parameter NMOD = 3
) (
  input  wire logic            clk_sys,
  input  wire logic [NMOD-1:0] key_osc_run,
  input  wire logic [NMOD-1:0] ref_osc_run,
  output var  logic [NMOD-1:0] key_osc_in,
  output var  logic [NMOD-1:0] ref_osc_in
);
  logic ph_ff;
  initial
  begin
    key_osc_in = '0;
    ref_osc_in = '0;
    ph_ff = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    ph_ff <= ~ph_ff;
    key_osc_in <= key_osc_in ^ key_osc_run;
    ref_osc_in <= ref_osc_in ^ (ref_osc_run & {NMOD{ph_ff}});
  end
endmodule // tkm_pads
`default_nettype wire

//--- dv/touch_key_measurement_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkm_map.vh"
module touch_key_measurement_control_tb;
  localparam NM = 3;
  logic clk_sys, rst_b, hsel, hwrite, r;
  logic [11:0] haddr, mb;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  wire [NM-1:0] kin, rin, krun, rrun, mfe, fle, hop;
  wire [2*NM-1:0] mux;
  wire [3*NM-1:0] swf;
  wire [10*NM-1:0] trim;
  wire [4*NM-1:0] pfs;
  wire [1:0] kfs;
  int n_fail, n_tests, cyc, k, m, t, i;
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  tkm_ctrl #(.NMOD(NM)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .key_osc_in(kin), .ref_osc_in(rin), .key_osc_run(krun), .ref_osc_run(rrun),
    .key_mux_select(mux), .multi_freq_enable(mfe), .filter_enable(fle), .hop_hw_control(hop),
    .sw_freq_code(swf), .ref_cap_trim(trim), .pin_function_select(pfs), .key_osc_freq_select(kfs),
    .touch_irq_request(irq));
  tkm_pads #(.NMOD(NM)) pads (.clk_sys(clk_sys), .key_osc_run(krun), .ref_osc_run(rrun),
    .key_osc_in(kin), .ref_osc_in(rin));
  // Data is taken at the falling edge, half a cycle before the rising edge, so a same-step update cannot race the read
  task wt;
    do
    begin
      @(negedge clk_sys);
      q = hrdata;
      r = hreadyout;
      @(posedge clk_sys);
    end while (r !== 1'b1);
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize;
    end
  end
  initial
  begin
    {hsel, hwrite, haddr, htrans, hwdata, rst_b, n_fail, n_tests, cyc} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 5 + 8 * NM; i++)
      rc(i < 5 ? i * 4 : 12'h040 + (i - 5) / 8 * 32 + (i - 5) % 8 * 4, 0);
    rc(12'h0fc, 0);
    for (k = 0; k < 4; k++)
    begin
      xf(1'b1, `TKM_A_FSEL, 32'hfc | k);
      rc(`TKM_A_FSEL, k);
      chk("kfs", k, kfs);
    end
    xf(1'b1, `TKM_A_GCTL, 32'h98);
    rc(`TKM_A_GCTL, 32'h18);
    xf(1'b1, `TKM_A_GCTL, 32'h0);
    rc(`TKM_A_GCTL, 32'h0);
    for (m = 0; m < NM; m++)
    begin
      mb = 12'h040 + m * 32;
      for (k = 0; k < 8; k++)
      begin
        t = ((k & 3) << 6) | ((k & 1) << 5) | ((k & 2) << 3) | k;
        xf(1'b1, mb + 16, t);
        rc(mb + 16, t);
        chk("mux", k & 3, mux[2*m+:2]);
        chk("mfe", k & 1, mfe[m]);
        chk("fle", (k >> 1) & 1, fle[m]);
        chk("swf", k, swf[3*m+:3]);
      end
      xf(1'b1, mb + 16, 32'h0f);
      @(negedge clk_sys);
      chk("hop", 1, hop[m]);
      chk("swf", 0, swf[3*m+:3]);
      xf(1'b1, mb + 8, 32'ha5);
      xf(1'b1, mb + 12, 32'hff);
      rc(mb + 12, 32'h3);
      chk("trim", 32'h3a5, trim[10*m+:10]);
      xf(1'b1, mb + 20, 32'hff);
      rc(mb + 20, 32'hbf);
      chk("pfs", 32'hf, pfs[4*m+:4]);
      xf(1'b1, mb, 32'hff);
      rc(mb, 0);
      xf(1'b1, mb + 20, 32'hb0);
    end
    xf(1'b1, `TKM_A_S16L, 32'hff);
    rc(`TKM_A_S16L, 0);
    xf(1'b1, `TKM_A_TMR, 32'hff);
    // One preset tick of 32 slot clocks at fsys/4 gives a 128 cycle window
    for (k = 0; k < 4; k++)
    begin
      xf(1'b1, `TKM_A_GCTL, ((k & 1) << 2) | k);
      rc(`TKM_A_S16L, 0);
      xf(1'b1, `TKM_A_GCTL, 32'h20 | ((k & 1) << 2) | k);
      repeat (2) @(negedge clk_sys);
      chk("krun", 32'h7, krun & rrun);
      for (t = 0; irq !== 1'b1 && t < 1000; t++)
        @(negedge clk_sys);
      chk("slot", 1, t >= 110 && t <= 140);
      chk("krun", 0, krun | rrun);
      rc(`TKM_A_GCTL, 32'h60 | ((k & 1) << 2) | k);
      xf(1'b0, `TKM_A_S16L, 32'h0);
      chk("s16", 1, q >= (128 >> k) - 6 && q <= (128 >> k) + 6);
      rc(`TKM_A_S16L, q);
    end
    xf(1'b0, 12'h040, 32'h0);
    chk("cnt", 1, q >= 50 && q <= 70);
    // Slot clock from the reference oscillator, one rise every 4 cycles
    for (m = 0; m < NM; m++)
      xf(1'b1, 12'h040 + m * 32 + 20, 32'h30);
    xf(1'b1, `TKM_A_GCTL, 32'h04);
    xf(1'b1, `TKM_A_GCTL, 32'h24);
    for (t = 0; irq !== 1'b1 && t < 1000; t++)
      @(negedge clk_sys);
    chk("refslot", 1, t >= 110 && t <= 150);
    xf(1'b1, `TKM_A_GCTL, 32'h0);
    rc(12'h040, 0);
    rc(`TKM_A_TMR, 32'hff);
    summarize;
  end
endmodule // touch_key_measurement_control_tb
`default_nettype wire
